// ==== hw/qsp_pkg.sv ====
/*
 Shared constants and carrier types for the quad-rate burst memory port:
 widths, burst shape, lane layout, reset values and the reset hand-over states.
 Assumes it is compiled before every other design file and is used only by
 qualified reference.
*/
// Contract
// R1: Write data sampled on both strobe rises
// R2: Low write select on true rise starts write
// R3: Deselected write port ignores write data
// R4: Byte selects sampled with their data beats
// R5: Low select gates [8:0], high [17:9]
// R6: Address captured on true rise at start
// R7: One shared address bus for both ports
// R8: Twenty address bits, four 1M x 18 arrays
// R9: Address ignored for a deselected port
// R10: Read words launched on both strobe rises
// R11: Low read select on true rise starts read
// R12: Read deselect never aborts a running burst
// R13: Output drivers off after next true rise
// R14: Every read returns four sequential words
// R15: Valid flag edges align with echo strobes
// R16: Every access begins on true strobe rise
// R17: Free-running echo strobes follow true strobe
// R18: Bypass input low selects single-cycle legacy latency
// R19: Read and write may start together
// R20: Valid flag low whenever no burst driven
package qsp_pkg;

    // Array shape
    localparam int ADDR_W     = 20;
    localparam int WORD_W     = 18;
    localparam int BURST_LEN  = 4;
    localparam int LANE_W     = 9;
    localparam int LANES      = 2;
    localparam int BURST_W    = WORD_W * BURST_LEN;
    localparam int KEEP_W     = LANES * BURST_LEN;
    localparam int LOW_LSB    = 0;
    localparam int HIGH_LSB   = 9;

    // Legacy mode ceiling on the strobe rate, in MHz
    localparam int LEGACY_MAX_MHZ = 167;
    // Reference clock rate, in MHz
    localparam int REF_CLK_MHZ    = 50;

    typedef logic [WORD_W-1:0] qsp_word_t;

    // One write beat: lane keep flags (active high) and the word
    typedef struct packed {
        logic [LANES-1:0] keep;
        qsp_word_t        data;
    } qsp_beat_t;

    // Words launched on one true rise and the following complementary rise
    typedef struct packed {
        logic      rise_vld;
        qsp_word_t rise_word;
        logic      fall_vld;
        qsp_word_t fall_word;
    } qsp_pair_t;

    localparam qsp_beat_t BEAT_RESET = '0;
    localparam qsp_pair_t PAIR_IDLE  = '0;

    // Reset hand-over toward the strobe domain
    typedef enum logic [1:0] {
        RST_IDLE    = 2'b00,
        RST_ASSERT  = 2'b01,
        RST_RELEASE = 2'b10
    } qsp_rst_state_t;

endpackage : qsp_pkg

// ==== hw/qsp_mem.sv ====
/*
 Burst-wide storage: each entry holds four words split into nine-bit lanes,
 each lane written on its own keep flag, read data registered.
 Assumes one write port and one read port on the same clock.
*/
`timescale 1ns/1ns
module qsp_mem #(
    parameter int ADDR_W = qsp_pkg::ADDR_W
) (
    // Clock
    input  wire logic                       clk,
    // Write port
    input  wire logic                       wr_en,
    input  wire logic [ADDR_W-1:0]          wr_addr,
    input  wire logic [qsp_pkg::BURST_W-1:0] wr_data,
    input  wire logic [qsp_pkg::KEEP_W-1:0] wr_keep,
    // Read port
    input  wire logic                       rd_en,
    input  wire logic [ADDR_W-1:0]          rd_addr,
    output logic      [qsp_pkg::BURST_W-1:0] rd_data
);

    localparam int DEPTH = 1 << ADDR_W;

    genvar lane;
    generate
        for (lane = 0; lane < qsp_pkg::KEEP_W; lane = lane + 1)
        begin : g_lane
            logic [qsp_pkg::LANE_W-1:0] lane_mem [DEPTH];

            // Lanes with a cleared keep flag hold their old contents
            always_ff @(posedge clk)
            begin
                if (wr_en && wr_keep[lane])
                begin
                    lane_mem[wr_addr] <= wr_data[lane*qsp_pkg::LANE_W +: qsp_pkg::LANE_W];
                end
                if (rd_en)
                begin
                    rd_data[lane*qsp_pkg::LANE_W +: qsp_pkg::LANE_W] <= lane_mem[rd_addr];
                end
            end
        end
    endgenerate

endmodule : qsp_mem

// ==== hw/qsp_port.sv ====
/*
 Quad-rate burst memory port: write and read ports sharing one address bus,
 double-rate data on the true and complementary input strobes, four-word
 bursts, byte-lane write masking, valid flag and echo strobes.
 Assumes the controller drives both strobes continuously as a complementary
 pair, keeps its inputs synchronous to them, and starts each port at most
 every other strobe cycle. The reference clock side only owns the reset.
*/
`timescale 1ns/1ns
module qsp_port #(
    parameter int ADDR_W = qsp_pkg::ADDR_W
) (
    // Reference clock and reset
    input  wire logic              ref_clk,
    input  wire logic              srst,
    output logic                   link_reset_busy,
    // Input strobes from the controller
    input  wire logic              k_clk,
    input  wire logic              k_n_clk,
    // Port selects and shared address
    input  wire logic              write_port_select_n,
    input  wire logic              read_port_select_n,
    input  wire logic [ADDR_W-1:0] addr,
    // Write data and byte selects
    input  wire logic [17:0]       wdata,
    input  wire logic              byte_write_sel_low_n,
    input  wire logic              byte_write_sel_high_n,
    // Read data, driver enable and valid flag
    output logic      [17:0]       rdata,
    output logic                   rdata_oe,
    output logic                   output_valid_flag,
    // Echo strobes
    output logic                   echo_strobe_true,
    output logic                   echo_strobe_comp,
    // Latency mode pin
    input  wire logic              pll_bypass_n
);

    // ------------------------------------------------------------------
    // Reference domain: reset hand-over
    // ------------------------------------------------------------------
    // A one-cycle srst is far shorter than a strobe period, so it is held as
    // a request until the strobe side acknowledges it.
    qsp_pkg::qsp_rst_state_t rst_state_reg;
    qsp_pkg::qsp_rst_state_t rst_state_next;
    logic                    rst_req_reg;
    logic                    busy_reg;
    logic                    ack_meta_reg;
    logic                    ack_sync_reg;
    logic                    k_rst_meta_reg;
    logic                    k_rst_reg;

    always_comb
    begin
        rst_state_next = rst_state_reg;
        unique case (rst_state_reg)
            qsp_pkg::RST_IDLE:    rst_state_next = qsp_pkg::RST_IDLE;
            qsp_pkg::RST_ASSERT:
                if (ack_sync_reg)
                    rst_state_next = qsp_pkg::RST_RELEASE;
            qsp_pkg::RST_RELEASE:
                if (!ack_sync_reg)
                    rst_state_next = qsp_pkg::RST_IDLE;
            default:              rst_state_next = qsp_pkg::RST_ASSERT;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rst_state_reg <= qsp_pkg::RST_ASSERT;
            rst_req_reg   <= 1'b1;
            busy_reg      <= 1'b1;
        end
        else
        begin
            rst_state_reg <= rst_state_next;
            rst_req_reg   <= (rst_state_next == qsp_pkg::RST_ASSERT);
            busy_reg      <= (rst_state_next != qsp_pkg::RST_IDLE);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        ack_meta_reg <= k_rst_reg;
        ack_sync_reg <= ack_meta_reg;
    end

    assign link_reset_busy = busy_reg;

    // ------------------------------------------------------------------
    // Strobe domain: reset and mode synchronisers
    // ------------------------------------------------------------------
    logic byp_meta_reg;
    logic byp_sync_reg;

    always_ff @(posedge k_clk)
    begin
        k_rst_meta_reg <= rst_req_reg;
        k_rst_reg      <= k_rst_meta_reg;
        byp_meta_reg   <= pll_bypass_n;
        byp_sync_reg   <= byp_meta_reg;
    end

    // Mode changes are meant to happen only while both ports are idle
    wire legacy_mode = ~byp_sync_reg;                                    // [R18]

    // Echo strobes are the input strobes passed straight back
    assign echo_strobe_true = k_clk;                                     // [R17]
    assign echo_strobe_comp = k_n_clk;                                   // [R17]

    // ------------------------------------------------------------------
    // Port starts on the true strobe rise
    // ------------------------------------------------------------------
    logic wr_p1_reg;
    logic wr_p2_reg;
    logic wr_p3_reg;
    logic rd_p1_reg;

    // Each port decides on its own select, so both may start together
    wire wr_start = ~write_port_select_n & ~wr_p1_reg & ~k_rst_reg;     // [R2] [R16] [R19]
    wire rd_start = ~read_port_select_n & ~rd_p1_reg & ~k_rst_reg;      // [R11] [R16] [R19]

    always_ff @(posedge k_clk)
    begin
        if (k_rst_reg)
        begin
            wr_p1_reg <= 1'b0;
            wr_p2_reg <= 1'b0;
            wr_p3_reg <= 1'b0;
            rd_p1_reg <= 1'b0;
        end
        else
        begin
            wr_p1_reg <= wr_start;
            wr_p2_reg <= wr_p1_reg;
            wr_p3_reg <= wr_p2_reg;
            rd_p1_reg <= rd_start;
        end
    end

    // ------------------------------------------------------------------
    // Write burst capture
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0]  wr_addr_reg;
    logic [ADDR_W-1:0]  wr_addr_commit_reg;
    qsp_pkg::qsp_beat_t beat0_reg;
    qsp_pkg::qsp_beat_t beat1_reg;
    qsp_pkg::qsp_beat_t beat2_reg;
    qsp_pkg::qsp_beat_t fall_beat_reg;

    wire qsp_pkg::qsp_beat_t pin_beat = '{keep: {~byte_write_sel_high_n,
                                                 ~byte_write_sel_low_n}, // [R4] [R5]
                                          data: wdata};

    // Complementary-rise half of each write cycle; outside a burst the
    // write data pins are simply not looked at
    wire fall_cap_en = wr_p2_reg | wr_p3_reg;                           // [R3]

    always_ff @(posedge k_n_clk)
    begin
        if (k_rst_reg)
        begin
            fall_beat_reg <= qsp_pkg::BEAT_RESET;
        end
        else if (fall_cap_en)
        begin
            fall_beat_reg <= pin_beat;                                   // [R1] [R4]
        end
    end

    // Address only taken at a write start; a deselected port leaves it alone
    always_ff @(posedge k_clk)
    begin
        if (wr_start)
        begin
            wr_addr_reg <= addr;                                         // [R6] [R7] [R9]
        end
        if (wr_p2_reg)
        begin
            wr_addr_commit_reg <= wr_addr_reg;
        end
    end

    always_ff @(posedge k_clk)
    begin
        if (k_rst_reg)
        begin
            beat0_reg <= qsp_pkg::BEAT_RESET;
            beat1_reg <= qsp_pkg::BEAT_RESET;
            beat2_reg <= qsp_pkg::BEAT_RESET;
        end
        else
        begin
            if (wr_p1_reg)
            begin
                beat0_reg <= pin_beat;                                   // [R1]
            end
            if (wr_p2_reg)
            begin
                beat1_reg <= fall_beat_reg;                              // [R1]
                beat2_reg <= pin_beat;                                   // [R1]
            end
        end
    end

    // Whole burst lands in one entry once the last beat is in
    wire                          mem_wr_en   = wr_p3_reg & ~k_rst_reg;
    wire [qsp_pkg::BURST_W-1:0]   mem_wr_data = {fall_beat_reg.data, beat2_reg.data,
                                                 beat1_reg.data, beat0_reg.data};
    wire [qsp_pkg::KEEP_W-1:0]    mem_wr_keep = {fall_beat_reg.keep, beat2_reg.keep,
                                                 beat1_reg.keep, beat0_reg.keep}; // [R5]

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [qsp_pkg::BURST_W-1:0] mem_rd_data;

    qsp_mem #(
        .ADDR_W (ADDR_W)                                                 // [R8]
    ) u_mem (
        .clk     (k_clk),
        .wr_en   (mem_wr_en),
        .wr_addr (wr_addr_commit_reg),
        .wr_data (mem_wr_data),
        .wr_keep (mem_wr_keep),
        .rd_en   (rd_start),
        .rd_addr (addr),                                                 // [R6] [R7] [R9]
        .rd_data (mem_rd_data)
    );

    // ------------------------------------------------------------------
    // Read burst scheduling
    // ------------------------------------------------------------------
    qsp_pkg::qsp_word_t rd_word [qsp_pkg::BURST_LEN];

    genvar wi;
    generate
        for (wi = 0; wi < qsp_pkg::BURST_LEN; wi = wi + 1)
        begin : g_word
            assign rd_word[wi] = mem_rd_data[wi*qsp_pkg::WORD_W +: qsp_pkg::WORD_W];
        end
    endgenerate

    // Legacy: words start on the next true rise. Extended: they start a cycle and a
    // half later, on the complementary rise two and a half cycles after the start.
    wire ld_leg = rd_p1_reg & legacy_mode;                               // [R18]
    wire ld_ext = rd_p1_reg & ~legacy_mode;

    wire qsp_pkg::qsp_pair_t ld0 = ld_leg ? '{1'b1, rd_word[0], 1'b1, rd_word[1]}
                                          : qsp_pkg::PAIR_IDLE;          // [R14]
    wire qsp_pkg::qsp_pair_t ld1 = ld_leg ? '{1'b1, rd_word[2], 1'b1, rd_word[3]}
                                 : ld_ext ? '{1'b0, '0, 1'b1, rd_word[0]}
                                          : qsp_pkg::PAIR_IDLE;          // [R14]
    wire qsp_pkg::qsp_pair_t ld2 = ld_ext ? '{1'b1, rd_word[1], 1'b1, rd_word[2]}
                                          : qsp_pkg::PAIR_IDLE;
    wire qsp_pkg::qsp_pair_t ld3 = ld_ext ? '{1'b1, rd_word[3], 1'b0, '0}
                                          : qsp_pkg::PAIR_IDLE;

    // Back-to-back bursts never claim the same half cycle, so a merge is safe
    function automatic qsp_pkg::qsp_pair_t pair_merge(input qsp_pkg::qsp_pair_t old_p,
                                                      input qsp_pkg::qsp_pair_t new_p);
        qsp_pkg::qsp_pair_t res;
        res = old_p;
        if (new_p.rise_vld)
        begin
            res.rise_vld  = 1'b1;
            res.rise_word = new_p.rise_word;
        end
        if (new_p.fall_vld)
        begin
            res.fall_vld  = 1'b1;
            res.fall_word = new_p.fall_word;
        end
        return res;
    endfunction : pair_merge

    qsp_pkg::qsp_pair_t out_reg;
    qsp_pkg::qsp_pair_t s1_reg;
    qsp_pkg::qsp_pair_t s2_reg;
    qsp_pkg::qsp_pair_t s3_reg;

    wire qsp_pkg::qsp_pair_t out_next = pair_merge(s1_reg, ld0);
    wire qsp_pkg::qsp_pair_t s1_next  = pair_merge(s2_reg, ld1);
    wire qsp_pkg::qsp_pair_t s2_next  = pair_merge(s3_reg, ld2);

    // The schedule runs on regardless of the read select
    always_ff @(posedge k_clk)
    begin
        if (k_rst_reg)
        begin
            out_reg <= qsp_pkg::PAIR_IDLE;
            s1_reg  <= qsp_pkg::PAIR_IDLE;
            s2_reg  <= qsp_pkg::PAIR_IDLE;
            s3_reg  <= qsp_pkg::PAIR_IDLE;
        end
        else
        begin
            out_reg <= out_next;                                         // [R10] [R12] [R13]
            s1_reg  <= s1_next;                                          // [R12]
            s2_reg  <= s2_next;
            s3_reg  <= ld3;
        end
    end

    // ------------------------------------------------------------------
    // Complementary-rise launch and double-rate output
    // ------------------------------------------------------------------
    qsp_pkg::qsp_word_t fall_word_reg;
    logic               fall_vld_reg;

    always_ff @(posedge k_n_clk)
    begin
        if (k_rst_reg)
        begin
            fall_word_reg <= '0;
            fall_vld_reg  <= 1'b0;
        end
        else
        begin
            fall_word_reg <= out_reg.fall_word;                          // [R10]
            fall_vld_reg  <= out_reg.fall_vld;
        end
    end

    // Select follows the true strobe, so flag edges line up with the echoes
    wire drive_vld = k_clk ? out_reg.rise_vld : fall_vld_reg;           // [R15] [R20]

    assign rdata             = k_clk ? out_reg.rise_word : fall_word_reg; // [R10]
    assign rdata_oe          = drive_vld;                                // [R13]
    assign output_valid_flag = drive_vld;                                // [R15] [R20]

endmodule : qsp_port

// ==== testbench/qsp_port_sva.sv ====
/*
 Pin checker for the burst memory port, bound into every qsp_port.
 Assumes k_n_clk is the inverse of k_clk and that link_reset_busy covers the strobe-side reset.
*/
`timescale 1ns/1ns
module qsp_port_sva #(
    parameter int ADDR_W = 20
) (
    // Reference side
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic              link_reset_busy,
    // Strobes and requests
    input wire logic              k_clk,
    input wire logic              k_n_clk,
    input wire logic              write_port_select_n,
    input wire logic              read_port_select_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [17:0]       wdata,
    input wire logic              byte_write_sel_low_n,
    input wire logic              byte_write_sel_high_n,
    input wire logic              pll_bypass_n,
    // Read side and echoes
    input wire logic [17:0]       rdata,
    input wire logic              rdata_oe,
    input wire logic              output_valid_flag,
    input wire logic              echo_strobe_true,
    input wire logic              echo_strobe_comp
);
    // A select held low is not a new start, so the previous level is kept
    logic       rps_prev_reg;
    logic       wps_prev_reg;
    logic [2:0] idle_cnt_reg;
    logic [2:0] idle_cnt_next;
    logic       k_rst;
    logic       rd_start;
    logic       wr_start;

    assign k_rst         = srst || link_reset_busy;
    assign rd_start      = !read_port_select_n && rps_prev_reg;
    assign wr_start      = !write_port_select_n && wps_prev_reg;
    assign idle_cnt_next = !read_port_select_n ? 3'h0 : ((idle_cnt_reg == 3'h7) ? 3'h7 : idle_cnt_reg + 3'h1);

    always_ff @(posedge k_clk)
    begin
        rps_prev_reg <= k_rst | read_port_select_n;
        wps_prev_reg <= k_rst | write_port_select_n;
        idle_cnt_reg <= k_rst ? 3'h7 : idle_cnt_next;
    end

    a_legacy_latency: assert property (@(posedge k_clk) disable iff (k_rst)
        rd_start && !pll_bypass_n && idle_cnt_reg >= 3'h5 |-> ##1 !rdata_oe ##1 rdata_oe [*2])
        else $error("legacy read burst not on the two rises after start");
    a_extended_latency: assert property (@(posedge k_clk) disable iff (k_rst)
        rd_start && pll_bypass_n && idle_cnt_reg >= 3'h5 |-> ##1 !rdata_oe [*2] ##1 rdata_oe [*2])
        else $error("extended read burst timing wrong");
    a_legacy_release: assert property (@(posedge k_clk) disable iff (k_rst)
        rd_start && !pll_bypass_n ##2 read_port_select_n |-> ##2 !rdata_oe)
        else $error("legacy read drivers not released");
    a_extended_release: assert property (@(posedge k_clk) disable iff (k_rst)
        rd_start && pll_bypass_n ##2 read_port_select_n |-> ##3 !rdata_oe)
        else $error("extended read drivers not released");
    a_idle_quiet: assert property (@(posedge k_clk) disable iff (k_rst)
        idle_cnt_reg >= 3'h5 |-> !rdata_oe && !output_valid_flag)
        else $error("valid or driver enable high with no burst");
    a_valid_on_rise: assert property (@(posedge ref_clk) disable iff (srst)
        $changed(output_valid_flag) |-> $changed(echo_strobe_true))
        else $error("valid flag moved between echo strobe edges");
    a_valid_on_fall: assert property (@(posedge k_n_clk) disable iff (k_rst)
        output_valid_flag == rdata_oe)
        else $error("valid flag differs from driver enable at comp rise");
    a_echo_follows: assert property (@(posedge ref_clk) disable iff (srst)
        echo_strobe_true == k_clk && echo_strobe_comp == k_n_clk)
        else $error("echo strobes do not follow input strobes");

    c_legacy_read: cover property (@(posedge k_clk) disable iff (k_rst) rd_start && !pll_bypass_n);
    c_extended_read: cover property (@(posedge k_clk) disable iff (k_rst) rd_start && pll_bypass_n);
    c_joint_start: cover property (@(posedge k_clk) disable iff (k_rst) rd_start && wr_start);
endmodule : qsp_port_sva

bind qsp_port qsp_port_sva #(.ADDR_W(ADDR_W)) i_sva (
    .ref_clk(ref_clk), .srst(srst), .link_reset_busy(link_reset_busy), .k_clk(k_clk), .k_n_clk(k_n_clk),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n), .addr(addr),
    .wdata(wdata), .byte_write_sel_low_n(byte_write_sel_low_n), .byte_write_sel_high_n(byte_write_sel_high_n),
    .pll_bypass_n(pll_bypass_n), .rdata(rdata), .rdata_oe(rdata_oe), .output_valid_flag(output_valid_flag),
    .echo_strobe_true(echo_strobe_true), .echo_strobe_comp(echo_strobe_comp)
);

// ==== testbench/qsp_ctrl_model.sv ====
/*
 Memory controller model: free-running input strobes, write and read bursts.
 Assumes callers start one burst per port at a time; idle lines carry junk on purpose.
*/
`timescale 1ns/1ns
module qsp_ctrl_model #(
    parameter int ADDR_W = 20
) (
    // Strobes
    output logic              k_clk,
    output logic              k_n_clk,
    // Requests and write data
    output logic              write_port_select_n,
    output logic              read_port_select_n,
    output logic [ADDR_W-1:0] addr,
    output logic [17:0]       wdata,
    output logic              byte_write_sel_low_n,
    output logic              byte_write_sel_high_n,
    output logic              pll_bypass_n,
    // Read side
    input  wire logic [17:0]  rdata,
    input  wire logic         rdata_oe,
    input  wire logic         output_valid_flag
);
    assign k_n_clk = ~k_clk;

    // Odd start offset keeps strobe edges off the reference edges
    initial
    begin
        k_clk = 1'b0;
        write_port_select_n = 1'b1;
        read_port_select_n = 1'b1;
        addr = '0;
        wdata = 18'h00000;
        byte_write_sel_low_n = 1'b1;
        byte_write_sel_high_n = 1'b1;
        pll_bypass_n = 1'b0;
        #7;
        forever #80 k_clk = ~k_clk;
    end

    task automatic wr_burst(input logic [ADDR_W-1:0] a, input logic [71:0] w, input logic [7:0] keep);
        @(posedge k_clk);
        write_port_select_n <= 1'b0;
        addr                <= a;
        @(posedge k_clk);
        write_port_select_n <= 1'b1;
        addr                <= ~a;
        // Beat i is set up half a cycle before the rise that samples it; a fifth step leaves junk
        for (int i = 0; i < 5; i++)
        begin
            @(posedge k_clk or posedge k_n_clk);
            wdata                 <= (i < 4) ? w[i*18 +: 18] : ~wdata;
            byte_write_sel_low_n  <= (i < 4) ? ~keep[2*i] : ~byte_write_sel_low_n;
            byte_write_sel_high_n <= (i < 4) ? ~keep[2*i+1] : ~byte_write_sel_high_n;
        end
    endtask : wr_burst

    task automatic rd_burst(input logic [ADDR_W-1:0] a, output logic [71:0] q, output logic [4:0] flg);
        int lat;
        lat = pll_bypass_n ? 5 : 2;
        @(posedge k_clk);
        read_port_select_n <= 1'b0;
        addr               <= a;
        @(posedge k_clk);
        read_port_select_n <= 1'b1;
        addr               <= ~a;
        repeat (lat - 1) @(posedge k_clk or posedge k_n_clk);
        // Sample mid half cycle; the fifth sample must see the drivers released
        for (int i = 0; i < 5; i++)
        begin
            @(posedge k_clk or posedge k_n_clk);
            #40;
            if (i < 4)
                q[i*18 +: 18] = rdata;
            flg[i] = rdata_oe & output_valid_flag;
        end
    endtask : rd_burst
endmodule : qsp_ctrl_model

// ==== testbench/tb_top.sv ====
/*
 Top bench: reference clock, reset, port, controller model and expected contents.
 Assumes a six-bit address so the expected contents fit a plain array.
*/
`timescale 1ns/1ns
module tb_top;
    localparam int AW = 6;
    logic          ref_clk;
    logic          srst;
    logic          link_reset_busy;
    logic          k_clk;
    logic          k_n_clk;
    logic          wps_n;
    logic          rps_n;
    logic [AW-1:0] addr;
    logic [17:0]   wdata;
    logic          bsel_low_n;
    logic          bsel_high_n;
    logic          bypass_n;
    logic [17:0]   rdata;
    logic          rdata_oe;
    logic          vld;
    int            mismatches;
    int            checked;
    integer        seed;
    logic [71:0]   ref_mem [0:63];
    logic [71:0]   got;
    logic [71:0]   w;
    logic [71:0]   old_v;
    logic [4:0]    flg;
    logic [AW-1:0] a;

    qsp_port #(.ADDR_W(AW)) i_dut (
        .ref_clk(ref_clk), .srst(srst), .link_reset_busy(link_reset_busy), .k_clk(k_clk), .k_n_clk(k_n_clk),
        .write_port_select_n(wps_n), .read_port_select_n(rps_n), .addr(addr), .wdata(wdata),
        .byte_write_sel_low_n(bsel_low_n), .byte_write_sel_high_n(bsel_high_n), .rdata(rdata),
        .rdata_oe(rdata_oe), .output_valid_flag(vld), .echo_strobe_true(), .echo_strobe_comp(),
        .pll_bypass_n(bypass_n)
    );
    qsp_ctrl_model #(.ADDR_W(AW)) i_ctrl (
        .k_clk(k_clk), .k_n_clk(k_n_clk), .write_port_select_n(wps_n), .read_port_select_n(rps_n),
        .addr(addr), .wdata(wdata), .byte_write_sel_low_n(bsel_low_n), .byte_write_sel_high_n(bsel_high_n),
        .pll_bypass_n(bypass_n), .rdata(rdata), .rdata_oe(rdata_oe), .output_valid_flag(vld)
    );

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    function automatic logic [71:0] merge(input logic [71:0] old, input logic [71:0] d, input logic [7:0] keep);
        logic [71:0] r;
        r = old;
        for (int i = 0; i < 8; i++)
            if (keep[i])
                r[i*9 +: 9] = d[i*9 +: 9];
        return r;
    endfunction : merge

    task automatic chk(input logic [71:0] got_v, input logic [71:0] exp_v);
        checked++;
        if (got_v !== exp_v)
        begin
            mismatches++;
            $display("BAD at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask : chk

    task automatic do_wr(input logic [AW-1:0] wa, input logic [7:0] wk);
        w = 72'({$random(seed), $random(seed), $random(seed)});
        i_ctrl.wr_burst(wa, w, wk);
        ref_mem[wa] = merge(ref_mem[wa], w, wk);
    endtask : do_wr

    task automatic do_rd(input logic [AW-1:0] ra);
        i_ctrl.rd_burst(ra, got, flg);
        chk(got, ref_mem[ra]);
        chk(72'(flg), 72'h0f);
    endtask : do_rd

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // Both modes take about 2,000 reference cycles; ten times that means a hang
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        seed = 32'hf1d0b107;
        mismatches = 0;
        checked = 0;
        srst = 1'b1;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        while (link_reset_busy !== 1'b0)
            @(posedge ref_clk);
        for (int m = 0; m < 2; m++)
        begin
            i_ctrl.pll_bypass_n <= m[0];
            repeat (4) @(posedge k_clk);
            for (int n = 0; n < 8; n++)
            begin
                a = (n == 0) ? '0 : (n == 1) ? '1 : AW'($random(seed));
                do_wr(a, 8'hff);
                do_wr(a, (n == 2) ? 8'h00 : 8'($random(seed)));
                do_rd(a);
            end
            // Both ports start on one rise; the read sees the contents from before the write
            old_v = ref_mem[a];
            w = 72'({$random(seed), $random(seed), $random(seed)});
            fork
                i_ctrl.wr_burst(a, w, 8'h5a);
                i_ctrl.rd_burst(a, got, flg);
            join
            chk(got, old_v);
            ref_mem[a] = merge(ref_mem[a], w, 8'h5a);
            do_rd(a);
            $display("Mode %0d test done, %0d comparisons so far", m, checked);
        end
        give_verdict();
    end
endmodule : tb_top
